// [hdl/psu_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module psu_seq
    import psu_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF
)(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        at_home,
    input  wire logic        at_zero,
    input  wire logic        at_purge_a,
    input  wire logic        at_purge_b,
    input  wire logic [15:0] xmtr_current,
    output logic             zero_set_req,
    input  wire logic        zero_set_done,
    input  wire logic        zero_set_fail,
    input  wire logic        chain_go,
    input  wire logic        peer_busy,
    output logic             next_unit,
    output logic             motor_on,
    output logic             op_indicator,
    output logic             unit_error,
    output logic             calc_stop,
    output logic             relay_out,
    output logic             switch_output_one,
    output logic             switch_output_two
);

    // register array indexes
    localparam logic [3:0] I_CTRL   = REG_CTRL[5:2];
    localparam logic [3:0] I_CHECK  = REG_CHECK[5:2];
    localparam logic [3:0] I_PURGE  = REG_PURGE[5:2];
    localparam logic [3:0] I_SETTLE = REG_SETTLE[5:2];
    localparam logic [3:0] I_MOTTO  = REG_MOTTO[5:2];
    localparam logic [3:0] I_TIMER  = REG_TIMER[5:2];
    localparam logic [3:0] I_IMIN   = REG_IMIN[5:2];
    localparam logic [3:0] I_IMAX   = REG_IMAX[5:2];
    localparam logic [3:0] I_PRECAL = REG_PRECAL[5:2];
    localparam logic [3:0] I_ROUTE  = REG_ROUTE[5:2];
    localparam logic [3:0] I_CALREF = REG_CALREF[5:2];
    localparam logic [3:0] I_CMD    = REG_CMD[5:2];
    localparam logic [3:0] I_STATUS = REG_STATUS[5:2];
    localparam logic [3:0] I_LIMIT  = 4'(CFG_N);

    // select one status source for a switch output
    function automatic logic route_sel(input logic [1:0] src,
                                       input logic       mot,
                                       input logic       busy,
                                       input logic       err,
                                       input logic       nxt);
        case (src)
            SRC_MOTOR: route_sel = mot;
            SRC_BUSY:  route_sel = busy;
            SRC_ERROR: route_sel = err;
            default:   route_sel = nxt;
        endcase
    endfunction

    logic [15:0] cfg_q [CFG_N];
    logic        ack_q;
    logic [31:0] rdata_q;
    psu_state_t  state_q;
    psu_state_t  state_d;
    logic        zero_err_q;
    logic        drive_err_q;
    logic        wire_err_q;
    logic        next_q;
    logic        zreq_q;
    logic        pend_q;
    logic        cyc_q;
    logic [23:0] ph_sec;
    logic [23:0] iv_sec;

    // bus handshake: one wait state on every access
    wire         req     = avs_read | avs_write;
    wire         first   = req & ~ack_q;
    wire  [3:0]  widx    = avs_address[5:2];
    wire         wr_en   = avs_write & ack_q;
    wire         wr_cfg  = wr_en & (widx < I_LIMIT);
    wire         wr_cmd  = wr_en & (widx == I_CMD);
    wire  [15:0] cmd     = wr_cmd ? psu_merge16(16'h0000, avs_writedata[15:0],
                                                avs_byteenable[1:0]) : 16'h0000;
    wire         cmd_start    = cmd[CMD_START];
    wire         cmd_to_zero  = cmd[CMD_TO_ZERO];
    wire         cmd_to_home  = cmd[CMD_TO_HOME];
    wire         cmd_set_zero = cmd[CMD_SET_ZERO];
    wire         cmd_clr_err  = cmd[CMD_CLR_ERR];

    // named configuration fields
    wire  [15:0] ctrl      = cfg_q[I_CTRL];
    wire  [15:0] check_s   = cfg_q[I_CHECK];
    wire  [15:0] purge_s   = cfg_q[I_PURGE];
    wire  [15:0] settle_s  = cfg_q[I_SETTLE];
    wire  [15:0] motto_s   = cfg_q[I_MOTTO];
    wire  [15:0] timer_min = cfg_q[I_TIMER];
    wire  [15:0] i_min     = cfg_q[I_IMIN];
    wire  [15:0] i_max     = cfg_q[I_IMAX];
    wire  [15:0] precal    = cfg_q[I_PRECAL];
    wire  [15:0] route     = cfg_q[I_ROUTE];
    wire  [15:0] calref    = cfg_q[I_CALREF];
    wire         timer_en  = ctrl[CTL_TIMER_EN];

    // correction allowed only with HART input and source
    wire         hart_ok = ctrl[CTL_HART_INPUT] & ctrl[CTL_HART_SRC];     // RULE_11
    wire         auto_on = ctrl[CTL_AUTO_EN] & hart_ok;                   // RULE_11
    wire         cfg_err = ctrl[CTL_AUTO_EN] & ~hart_ok;                  // RULE_11

    // state decode
    wire         idle    = (state_q == ST_IDLE);
    wire         in_zset = (state_q == ST_ZSET);
    wire         in_man  = (state_q == ST_MANUAL);
    wire         moving  = (state_q == ST_MV_ZERO) | (state_q == ST_MV_PA)
                         | (state_q == ST_MV_PB)   | (state_q == ST_MV_HOME)
                         | (state_q == ST_MV_MAN)  | (state_q == ST_MV_ERR);

    // target position reached for the current move
    wire         pos_hit = ((state_q == ST_MV_ZERO) & at_zero)
                         | ((state_q == ST_MV_MAN)  & at_zero)
                         | ((state_q == ST_MV_PA)   & at_purge_a)
                         | ((state_q == ST_MV_PB)   & at_purge_b)
                         | ((state_q == ST_MV_HOME) & at_home)
                         | ((state_q == ST_MV_ERR)  & at_home);

    // phase time checks, all in whole seconds
    wire         mot_to     = moving & ~pos_hit & (ph_sec >= {8'h00, motto_s}); // RULE_06
    wire         check_done = (ph_sec >= {8'h00, check_s});                    // RULE_01
    wire         purge_done = (ph_sec >= {8'h00, purge_s});                    // RULE_04
    wire         settle_done = (ph_sec >= {8'h00, settle_s});                  // RULE_05
    wire         zset_to    = in_zset & (ph_sec >= {8'h00, motto_s});

    // zero-point evaluation at the end of the check phase
    wire         check_end = (state_q == ST_CHECK) & check_done;              // RULE_01
    wire         out_win   = (xmtr_current < i_min) | (xmtr_current > i_max); // RULE_02
    wire         pre_skip  = psu_absdiff(xmtr_current, calref) > precal;      // RULE_18
    wire         zset_go   = (check_end & auto_on & ~pre_skip)
                           | (in_man & cmd_set_zero & auto_on);
    wire         cal_take  = (in_zset | in_man) & zero_set_done;

    // zero failure events for both correction settings
    wire         ev_zero   = (check_end & ~auto_on & out_win)                 // RULE_03
                           | (check_end & auto_on & pre_skip)                 // RULE_10
                           | ((in_zset | in_man) & zero_set_fail)             // RULE_10
                           | zset_to;                                         // RULE_10

    // home indication lost while resting
    wire         home_lost = idle & ~at_home & ~drive_err_q;                  // RULE_08

    // waiting time between automatic cycles
    wire  [23:0] tmin_sec  = 24'({8'h00, timer_min} * SEC_PER_MIN);
    wire         timer_due = timer_en & idle & ~pend_q & (iv_sec >= tmin_sec); // RULE_17
    wire         iv_rst    = ~idle | ~timer_en | pend_q;

    // cycle starts only with partner idle and unit at home
    wire         go_start  = idle & pend_q & ~peer_busy & ~drive_err_q
                           & at_home;                                          // RULE_16
    wire         ev_req    = idle & (cmd_start | chain_go | timer_due);       // RULE_17
    wire         cyc_end   = (state_q == ST_SETTLE) & settle_done & cyc_q;    // RULE_19

    // phase timer restarts on every state change
    psu_sec_timer #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_phase (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .restart (state_d != state_q),
        .secs    (ph_sec)
    );

    // interval timer runs only while idle and armed
    psu_sec_timer #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_interval (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .restart (iv_rst),
        .secs    (iv_sec)
    );

    // sequence: check, purge both chambers, home, settle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (home_lost) begin
                    state_d = ST_MV_ERR;                                      // RULE_09
                end else if (go_start) begin
                    state_d = ST_MV_ZERO;
                end else if (cmd_to_zero && !drive_err_q) begin
                    state_d = ST_MV_MAN;
                end
            end
            ST_MV_ZERO: begin
                if (mot_to) begin
                    state_d = ST_MV_ERR;                                      // RULE_09
                end else if (at_zero) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (check_done) begin
                    state_d = zset_go ? ST_ZSET : ST_MV_PA;                   // RULE_18
                end
            end
            ST_ZSET: begin
                if (zero_set_done || zero_set_fail || zset_to) begin
                    state_d = ST_MV_PA;
                end
            end
            ST_MV_PA: begin
                if (mot_to) begin
                    state_d = ST_MV_ERR;
                end else if (at_purge_a) begin
                    state_d = ST_PURGE_A;
                end
            end
            ST_PURGE_A: begin
                if (purge_done) begin
                    state_d = ST_MV_PB;                                       // RULE_04
                end
            end
            ST_MV_PB: begin
                if (mot_to) begin
                    state_d = ST_MV_ERR;
                end else if (at_purge_b) begin
                    state_d = ST_PURGE_B;
                end
            end
            ST_PURGE_B: begin
                if (purge_done) begin
                    state_d = ST_MV_HOME;                                     // RULE_19
                end
            end
            ST_MV_HOME: begin
                if (mot_to) begin
                    state_d = ST_MV_ERR;
                end else if (at_home) begin
                    state_d = ST_SETTLE;                                      // RULE_19
                end
            end
            ST_SETTLE: begin
                if (settle_done) begin
                    state_d = ST_IDLE;                                        // RULE_05
                end
            end
            ST_MV_MAN: begin
                if (mot_to) begin
                    state_d = ST_MV_ERR;
                end else if (at_zero) begin
                    state_d = ST_MANUAL;
                end
            end
            ST_MANUAL: begin
                if (cmd_to_home) begin
                    state_d = ST_MV_HOME;
                end
            end
            ST_MV_ERR: begin
                if (at_home || mot_to) begin
                    state_d = ST_IDLE;                                        // RULE_09
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // configuration storage; calibration reference also taken by hardware
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int i = 0; i < CFG_N; i++) begin
                cfg_q[i] <= CFG_RST[i];
            end
        end else begin
            if (wr_cfg) begin
                cfg_q[widx] <= psu_merge16(cfg_q[widx], avs_writedata[15:0],
                                           avs_byteenable[1:0]);
            end
            if (cal_take) begin
                cfg_q[I_CALREF] <= xmtr_current;
            end
        end
    end

    // sticky error flags, an event beats a clear
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            zero_err_q  <= 1'b0;
            drive_err_q <= 1'b0;
            wire_err_q  <= 1'b0;
        end else begin
            zero_err_q  <= ev_zero | (zero_err_q & ~cmd_clr_err);           // RULE_03
            drive_err_q <= mot_to | (drive_err_q & ~cmd_clr_err);           // RULE_07
            wire_err_q  <= mot_to | home_lost | (wire_err_q & ~cmd_clr_err); // RULE_08
        end
    end

    // start request, cycle marker, hand-over and zero-set pulse
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pend_q <= 1'b0;
            cyc_q  <= 1'b0;
            next_q <= 1'b0;
            zreq_q <= 1'b0;
        end else begin
            pend_q <= ev_req | (pend_q & ~go_start);                        // RULE_17
            cyc_q  <= go_start | (cyc_q & ~cyc_end & ~idle);
            next_q <= cyc_end | (next_q & ~peer_busy & (state_d == ST_IDLE)); // RULE_15
            zreq_q <= zset_go;                                              // RULE_10
        end
    end

    // read data captured in the wait cycle
    wire  [31:0] status = {3'h0, state_q, 9'h000,
                           next_q, motor_on, op_indicator, wire_err_q,
                           drive_err_q, cfg_err, zero_err_q};
    wire  [31:0] rd_val = (widx < I_LIMIT)    ? {16'h0000, cfg_q[widx]} :
                          (widx == I_STATUS)  ? status : 32'h00000000;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= first;
            if (first) begin
                rdata_q <= rd_val;
            end
        end
    end

    assign avs_waitrequest = first;
    assign avs_readdata    = rdata_q;

    // pin outputs
    assign motor_on     = moving & ~pos_hit;                                  // RULE_12
    assign op_indicator = ~idle;                                              // RULE_13
    assign unit_error   = zero_err_q | cfg_err | drive_err_q | wire_err_q;   // RULE_14
    assign calc_stop    = drive_err_q;                                        // RULE_07
    assign next_unit    = next_q;                                             // RULE_15
    assign zero_set_req = zreq_q;

    // routable switch outputs, relay carries the motor by default
    assign relay_out         = route_sel(route[RT_RELAY_LSB +: 2], motor_on,
                                         op_indicator, unit_error, next_q);   // RULE_12
    assign switch_output_one = route_sel(route[RT_SW1_LSB +: 2], motor_on,
                                         op_indicator, unit_error, next_q);
    assign switch_output_two = route_sel(route[RT_SW2_LSB +: 2], motor_on,
                                         op_indicator, unit_error, next_q);

endmodule // psu_seq
`default_nettype wire

// [hdl/psu_pkg.sv]
// Summary of operation
// RULE_01: hold zero condition for check duration seconds
// RULE_02: compare transmitter current against min/max window
// RULE_03: correction off: window miss raises zero failure
// RULE_04: purge each chamber for purge duration seconds
// RULE_05: wait settling duration after reaching home
// RULE_06: bound every motor move by timeout seconds
// RULE_07: move timeout flags drive failure, stops calculation
// RULE_08: unreached target or lost home flags wire break
// RULE_09: wire break drives unit back home
// RULE_10: correction on: incomplete correction raises zero failure
// RULE_11: correction needs HART input and source, else error
// RULE_12: motor control signal, on relay by default
// RULE_13: indicator during purge cycle and manual control
// RULE_14: error output while any unit error active
// RULE_15: next-unit output hands control to one unit
// RULE_16: never purge while chained unit is busy; code checks peer_busy only at cycle start
// RULE_17: timer starts cycles every waiting time minutes
// RULE_18: correction skipped when pre-calibration deviation too large
// RULE_19: purge, home, settle; indicator released after settle
package psu_pkg;

    // clock rate and second prescale
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned ONE_SECOND_S   = 1;
    localparam int unsigned SEC_CYCLES_DEF = CLK_HZ * ONE_SECOND_S;
    localparam logic [23:0] SEC_PER_MIN    = 24'h00003C;

    // register byte offsets (one 32-bit word each)
    localparam logic [5:0] REG_CTRL   = 6'h00;
    localparam logic [5:0] REG_CHECK  = 6'h04;
    localparam logic [5:0] REG_PURGE  = 6'h08;
    localparam logic [5:0] REG_SETTLE = 6'h0C;
    localparam logic [5:0] REG_MOTTO  = 6'h10;
    localparam logic [5:0] REG_TIMER  = 6'h14;
    localparam logic [5:0] REG_IMIN   = 6'h18;
    localparam logic [5:0] REG_IMAX   = 6'h1C;
    localparam logic [5:0] REG_PRECAL = 6'h20;
    localparam logic [5:0] REG_ROUTE  = 6'h24;
    localparam logic [5:0] REG_CALREF = 6'h28;
    localparam logic [5:0] REG_CMD    = 6'h2C;
    localparam logic [5:0] REG_STATUS = 6'h30;
    localparam int unsigned CFG_N     = 11;

    // control fields
    localparam int unsigned CTL_TIMER_EN   = 0;
    localparam int unsigned CTL_AUTO_EN    = 1;
    localparam int unsigned CTL_HART_INPUT = 2;
    localparam int unsigned CTL_HART_SRC   = 3;

    // command fields, write-one pulses
    localparam int unsigned CMD_START    = 0;
    localparam int unsigned CMD_TO_ZERO  = 1;
    localparam int unsigned CMD_TO_HOME  = 2;
    localparam int unsigned CMD_SET_ZERO = 3;
    localparam int unsigned CMD_CLR_ERR  = 4;

    // output routing fields and sources
    localparam int unsigned RT_RELAY_LSB = 0;
    localparam int unsigned RT_SW1_LSB   = 2;
    localparam int unsigned RT_SW2_LSB   = 4;
    localparam logic [1:0]  SRC_MOTOR    = 2'h0;
    localparam logic [1:0]  SRC_BUSY     = 2'h1;
    localparam logic [1:0]  SRC_ERROR    = 2'h2;
    localparam logic [1:0]  SRC_NEXT     = 2'h3;

    // status fields
    localparam int unsigned ST_ZERO_ERR  = 0;
    localparam int unsigned ST_CFG_ERR   = 1;
    localparam int unsigned ST_DRIVE_ERR = 2;
    localparam int unsigned ST_WIRE_ERR  = 3;
    localparam int unsigned ST_BUSY      = 4;
    localparam int unsigned ST_MOTOR     = 5;
    localparam int unsigned ST_NEXT      = 6;
    localparam int unsigned ST_STATE_LSB = 16;

    // reset values, in offset order
    localparam logic [15:0] CFG_RST [CFG_N] = '{
        16'h0000,  // control
        16'h001E,  // check duration s
        16'h000A,  // purge duration s
        16'h001E,  // settling duration s
        16'h000F,  // motor timeout s
        16'h003C,  // waiting time min
        16'h0000,  // current minimum
        16'hFFFF,  // current maximum
        16'h0100,  // pre-calibration limit
        16'h0024,  // routing
        16'h0000   // calibration reference
    };

    typedef enum logic [12:0] {
        ST_IDLE    = 13'b0000000000001,
        ST_MV_ZERO = 13'b0000000000010,
        ST_CHECK   = 13'b0000000000100,
        ST_ZSET    = 13'b0000000001000,
        ST_MV_PA   = 13'b0000000010000,
        ST_PURGE_A = 13'b0000000100000,
        ST_MV_PB   = 13'b0000001000000,
        ST_PURGE_B = 13'b0000010000000,
        ST_MV_HOME = 13'b0000100000000,
        ST_SETTLE  = 13'b0001000000000,
        ST_MV_MAN  = 13'b0010000000000,
        ST_MANUAL  = 13'b0100000000000,
        ST_MV_ERR  = 13'b1000000000000
    } psu_state_t;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] psu_merge16(input logic [15:0] old_v,
                                                input logic [15:0] new_v,
                                                input logic [1:0]  be);
        psu_merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
                       be[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    // distance between two current readings
    function automatic logic [15:0] psu_absdiff(input logic [15:0] a,
                                                input logic [15:0] b);
        psu_absdiff = (a > b) ? (a - b) : (b - a);
    endfunction

endpackage

// [hdl/psu_sec_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module psu_sec_timer
    import psu_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF
)(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        restart,
    output logic [23:0]      secs
);
    localparam int unsigned PW = $clog2(SEC_CYCLES + 1);
    localparam logic [PW-1:0] LAST = PW'(SEC_CYCLES - 1);

    logic [PW-1:0] pre_q;
    logic [23:0]   sec_q;
    wire           wrap = (pre_q == LAST);
    wire           sat  = &sec_q;

    // prescaler and saturating seconds count since restart
    always_ff @(posedge clk_sys) begin
        if (!resetn || restart) begin
            pre_q <= '0;
            sec_q <= '0;
        end else begin
            pre_q <= wrap ? '0 : pre_q + 1'b1;
            if (wrap && !sat) begin
                sec_q <= sec_q + 24'h000001;
            end
        end
    end

    assign secs = sec_q;
endmodule // psu_sec_timer
`default_nettype wire

// [testbench/psu_seq_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module psu_seq_checker (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic at_home,
    input wire logic peer_busy,
    input wire logic next_unit,
    input wire logic motor_on,
    input wire logic op_indicator,
    input wire logic unit_error,
    input wire logic calc_stop,
    input wire logic relay_out,
    input wire logic switch_output_one,
    input wire logic switch_output_two
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // default routing and output meaning
    property p_relay; relay_out == motor_on; endproperty
    a_relay: assert property (p_relay) else $error("relay not motor");
    property p_sw1; switch_output_one == op_indicator; endproperty
    a_sw1: assert property (p_sw1) else $error("sw1 not indicator");
    property p_sw2; calc_stop |-> switch_output_two && unit_error; endproperty
    a_sw2: assert property (p_sw2) else $error("drive error not shown");
    property p_mind; motor_on |-> op_indicator; endproperty
    a_mind: assert property (p_mind) else $error("motor without indicator");
    // chaining with the peer unit
    property p_peer; peer_busy && !op_indicator && at_home |=> !op_indicator; endproperty
    a_peer: assert property (p_peer) else $error("start while peer busy");
    property p_next; op_indicator |-> !next_unit; endproperty
    a_next: assert property (p_next) else $error("next high while busy");
    property p_done; $rose(next_unit) |-> !op_indicator && $past(op_indicator); endproperty
    a_done: assert property (p_done) else $error("next not at cycle end");
    property p_home; $fell(op_indicator) && !calc_stop |-> at_home; endproperty
    a_home: assert property (p_home) else $error("cycle ended off home");
endmodule // psu_seq_checker
bind psu_seq psu_seq_checker u_chk (.clk_sys(clk_sys), .resetn(resetn), .at_home(at_home),
    .peer_busy(peer_busy), .next_unit(next_unit), .motor_on(motor_on),
    .op_indicator(op_indicator), .unit_error(unit_error), .calc_stop(calc_stop),
    .relay_out(relay_out), .switch_output_one(switch_output_one),
    .switch_output_two(switch_output_two));
`default_nettype wire

// [testbench/psu_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psu_drive_model #(parameter int DLY = 4) (
    input wire logic  clk_sys,
    input wire logic  resetn,
    input wire logic  motor_on,
    input wire logic  stall,
    output logic [3:0] pos_sw
);
    logic [1:0] pos_q;
    logic [3:0] run_q;
    // one-hot switches: home, zero, purge a, purge b
    assign pos_sw = 4'h1 << pos_q;
    // next position after DLY+1 motor cycles; stall jams the drive
    always_ff @(posedge clk_sys) begin
        if (!resetn || !motor_on || stall) begin
            run_q <= 4'h0;
        end else if (run_q == 4'(DLY)) begin
            run_q <= 4'h0;
            pos_q <= pos_q + 2'h1;
        end else begin
            run_q <= run_q + 4'h1;
        end
        if (!resetn) pos_q <= 2'h0;
    end
endmodule // psu_drive_model
`default_nettype wire

// [testbench/psu_seq_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module psu_seq_tb_top;
    import psu_pkg::*;
    logic clk_sys = 0, resetn = 0, avs_read = 0, avs_write = 0;
    logic chain_go = 0, peer_busy = 0, stall = 0;
    logic [5:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic [15:0] cur = 16'h0200;
    logic [3:0] sw;
    logic avs_waitrequest, next_unit, motor_on, op_indicator, unit_error, calc_stop;
    int n_errors = 0, n_checks = 0, busy_n = 0;
    logic [5:0] ra [6] = '{REG_CHECK, REG_PURGE, REG_SETTLE, REG_MOTTO, REG_IMIN, REG_IMAX};
    logic [15:0] rv [6] = '{16'h1, 16'h1, 16'h1, 16'h2, 16'h100, 16'h400};
    always #12.5 clk_sys = ~clk_sys;
    psu_seq #(.SEC_CYCLES(20)) DUT (.clk_sys(clk_sys), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .at_home(sw[0]), .at_zero(sw[1]),
        .at_purge_a(sw[2]), .at_purge_b(sw[3]), .xmtr_current(cur), .zero_set_req(),
        .zero_set_done(1'b0), .zero_set_fail(1'b0), .chain_go(chain_go),
        .peer_busy(peer_busy), .next_unit(next_unit), .motor_on(motor_on),
        .op_indicator(op_indicator), .unit_error(unit_error), .calc_stop(calc_stop),
        .relay_out(), .switch_output_one(), .switch_output_two());
    psu_drive_model u_drv (.clk_sys(clk_sys), .resetn(resetn), .motor_on(motor_on),
        .stall(stall), .pos_sw(sw));
    // busy length of a cycle
    always @(posedge clk_sys) if (op_indicator === 1'b1) busy_n <= busy_n + 1;
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_sys iff avs_waitrequest === 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_done;
        repeat (4) @(posedge clk_sys);
        @(posedge clk_sys iff op_indicator === 1'b0);
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        bus(0, REG_CHECK, 0);
        chk("check", 32'h1E, q);
        bus(0, REG_ROUTE, 0);
        chk("route", 32'h24, q);
        bus(0, 6'h34, 0);
        chk("unmapped", 32'h0, q);
        foreach (ra[i]) begin
            bus(1, ra[i], {16'h0, rv[i]});
            bus(0, ra[i], 0);
            chk("cfg", {16'h0, rv[i]}, q);
        end
        bus(1, REG_CMD, 32'h1);
        wait_done();
        chk("len", 1, busy_n >= 80 && busy_n < 160);
        bus(0, REG_STATUS, 0);
        chk("run1", 32'h0001_0040, q);
        peer_busy <= 1'b1;
        cur <= 16'h0500;
        chain_go <= 1'b1;
        @(posedge clk_sys);
        chain_go <= 1'b0;
        repeat (60) @(posedge clk_sys);
        chk("hold", 0, op_indicator);
        chk("next", 0, next_unit);
        peer_busy <= 1'b0;
        wait_done();
        bus(0, REG_STATUS, 0);
        chk("zero", 32'h0001_0041, q);
        chk("err", 1, unit_error);
        bus(1, REG_CMD, 32'h10);
        bus(1, REG_CTRL, 32'h2);
        bus(0, REG_STATUS, 0);
        chk("cfgerr", 32'h0001_0042, q);
        bus(1, REG_CTRL, 32'h0);
        stall <= 1'b1;
        bus(1, REG_CMD, 32'h1);
        wait_done();
        bus(0, REG_STATUS, 0);
        chk("drive", 32'h0001_000C, q);
        chk("stop", 1, calc_stop);
        stall <= 1'b0;
        bus(1, REG_CMD, 32'h10);
        bus(0, REG_STATUS, 0);
        chk("clear", 32'h0001_0000, q);
        end_sim();
    end
endmodule // psu_seq_tb_top
`default_nettype wire
